// File: common/wxz_pkg.sv
// Constants, types and helpers for the word store / XOR execution slice.
// Assumes one 20 MHz clock and a hub that grants one slot at a time.
// Functional notes
// - Hub word store writes low 16 bits
// - Store address comes from source operand
// - Hub instructions take 7 to 22 clocks
// - Store Z set unless long boundary; C zero
// - Store never writes; result bit means load
// - Z changes only with zero effect
// - Compare sets Z on equality, else clears it
// - XOR result written in 4 clocks
// - XOR Z set when result is zero
// - XOR C holds odd parity of result
package wxz_pkg;

    // Instruction field positions
    localparam int OPC_LSB  = 26;
    localparam int ZEFF_BIT = 25;
    localparam int CEFF_BIT = 24;
    localparam int REFF_BIT = 23;
    localparam int IMM_BIT  = 22;
    localparam int COND_LSB = 18;
    localparam int DST_LSB  = 9;
    localparam int SRC_LSB  = 0;

    // Opcode values
    localparam logic [5:0] OPC_HUB_WORD = 6'h01;
    localparam logic [5:0] OPC_XOR      = 6'h1B;
    localparam logic [5:0] OPC_CMP      = 6'h21;

    // Cycle counts
    localparam int ALU_CLOCKS     = 4;
    localparam int HUB_MIN_CLOCKS = 7;
    localparam int HUB_MAX_CLOCKS = 22;
    localparam logic [4:0] ALU_LAST = 5'(ALU_CLOCKS - 1);
    localparam logic [4:0] HUB_LAST = 5'(HUB_MIN_CLOCKS - 1);
    localparam logic [4:0] CNT_TOP  = 5'h1F;

    // Register byte offsets
    localparam logic [7:0] ADR_INSTR    = 8'h00;
    localparam logic [7:0] ADR_STATUS   = 8'h04;
    localparam logic [7:0] ADR_REG_IDX  = 8'h08;
    localparam logic [7:0] ADR_REG_DATA = 8'h0C;
    localparam logic [7:0] ADR_HUB      = 8'h10;

    // Status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_Z    = 1;
    localparam int ST_C    = 2;
    localparam int ST_ILL  = 3;
    localparam int ST_SKIP = 4;

    // Reset values
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic        FLAG_RST = 1'b0;

    // Operation kinds
    typedef enum logic [2:0] {
        OP_NONE  = 3'h0,
        OP_STORE = 3'h1,
        OP_LOAD  = 3'h2,
        OP_XOR   = 3'h3,
        OP_CMP   = 3'h4
    } wxz_op_t;

    // Sequencer states, Gray along idle-exec-hub-finish
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_EXEC = 2'h1,
        ST_HUBW = 2'h3,
        ST_FIN  = 2'h2
    } wxz_st_t;

    // Byte-lane merge of a bus write into a word
    function automatic logic [31:0] wxz_merge(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0]  sel
    );
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) r[i*8 +: 8] = new_w[i*8 +: 8];
        end
        return r;
    endfunction : wxz_merge

    // Condition field indexed by the current C and Z
    function automatic logic wxz_cond_pass(
        input logic [3:0] cond,
        input logic       z,
        input logic       c
    );
        return cond[{c, z}];
    endfunction : wxz_cond_pass

endpackage : wxz_pkg

// File: dv/wxz_exec_tb_top.sv
// Self-checking bench for the execution slice and its hub port.
// Assumes the hub stand-in model and Wishbone access to registers.
module wxz_exec_tb_top;
    import wxz_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_i, rst_i, cyc, stb, we, ack, hreq, hwe, grant;
    logic busy, z_o, c_o, s_we;
    logic [7:0]  adr;
    logic [31:0] dat, dato, seed, bcnt;
    logic [3:0]  sel, dly;
    logic [15:0] haddr, hwdata, hrdata, s_addr, s_data;
    int miscompares, n_tests;

    wxz_exec dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_sel_i(sel), .wb_ack_o(ack), .wb_dat_o(dato),
        .hub_req_o(hreq), .hub_we_o(hwe), .hub_addr_o(haddr),
        .hub_wdata_o(hwdata), .hub_grant_i(grant),
        .hub_rdata_i(hrdata), .busy_o(busy), .z_o(z_o), .c_o(c_o));
    wxz_hub_model hub (.clk_i(clk_i), .rst_i(rst_i), .req_i(hreq),
        .we_i(hwe), .addr_i(haddr), .wdata_i(hwdata), .dly_i(dly),
        .grant_o(grant), .rdata_o(hrdata), .seen_addr_o(s_addr),
        .seen_data_o(s_data), .seen_we_o(s_we));

    // Clock, 50 ns period
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Busy cycle counter, cleared before each instruction
    always @(posedge clk_i) begin
        if (busy === 1'b1) bcnt <= bcnt + 1;
    end

    // Verdict and end of run
    task automatic wrap_up();
        if (miscompares == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up

    // Compare seen against expected
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // Random word from the shift register
    function automatic logic [31:0] draw();
        for (int i = 0; i < 32; i++)
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : draw

    // Instruction word with condition always true
    function automatic logic [31:0] ins(logic [5:0] op, logic [3:0] f,
                                        logic [8:0] d, logic [8:0] s);
        return {op, f, 4'hF, d, s};
    endfunction : ins

    // One classic Wishbone cycle, waits for ack
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        if (n == 20) begin
            chk("wb_ack", 0, 1);
            wrap_up();
        end
        rd = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    // Register file write and read through the index
    task automatic setr(input logic [8:0] i, input logic [31:0] v);
        logic [31:0] x;
        wb(1'b1, ADR_REG_IDX, {23'h0, i}, x);
        wb(1'b1, ADR_REG_DATA, v, x);
    endtask : setr

    task automatic getr(input logic [8:0] i, output logic [31:0] v);
        logic [31:0] x;
        wb(1'b1, ADR_REG_IDX, {23'h0, i}, x);
        wb(1'b0, ADR_REG_DATA, 32'h0000_0000, v);
    endtask : getr

    // Start an instruction and wait, bounded, for it to finish
    task automatic run(input logic [31:0] w);
        logic [31:0] x;
        int n;
        bcnt = 0;
        wb(1'b1, ADR_INSTR, w, x);
        for (n = 0; n < 40; n++) begin
            if (busy === 1'b0) break;
            @(posedge clk_i);
        end
        if (n == 40) begin
            chk("busy_end", 0, 1);
            wrap_up();
        end
    endtask : run

    // Main sequence
    initial begin
        logic [31:0] d, s, r, v;
        logic        imm, wr, wz, ld;
        logic [15:0] a;
        miscompares = 0;
        n_tests = 0;
        seed = 32'h0000_0004;
        {cyc, stb, we} = 3'b000;
        adr = 8'h00;
        dat = 32'h0000_0000;
        sel = 4'hF;
        dly = 4'h0;
        bcnt = 0;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("rst_out", {ack, hreq, busy, z_o, c_o}, 0);
        wb(1'b0, 8'h20, 32'h0000_0000, v);
        chk("unmapped", v, 32'h0000_0000);
        // XOR: operand kinds, effects, equal operands
        for (int i = 0; i < 8; i++) begin
            d = draw();
            s = (i == 0) ? d : draw();
            imm = i[0];
            if (imm) s = {23'h0, s[8:0]};
            wr = (i != 5);
            wz = (i != 6);
            setr(9'd1, d);
            setr(9'd2, s);
            wb(1'b1, ADR_STATUS, 32'h0000_0006, v);
            run(ins(OPC_XOR, {wz, 1'b1, wr, imm}, 9'd1,
                    imm ? s[8:0] : 9'd2));
            r = d ^ s;
            chk("xor_clocks", bcnt, 4);
            getr(9'd1, v);
            chk("xor_dst", v, wr ? r : d);
            chk("xor_z", z_o, wz ? (r == 0) : 1'b1);
            chk("xor_c", c_o, ^r);
        end
        // Compare: equal then unequal, no result written
        for (int j = 0; j < 2; j++) begin
            d = draw();
            setr(9'd1, d);
            setr(9'd2, j ? ~d : d);
            run(ins(OPC_CMP, 4'b1000, 9'd1, 9'd2));
            chk("cmp_z", z_o, j == 0);
            getr(9'd1, v);
            chk("cmp_dst", v, d);
        end
        // Failed condition runs as a no-op; unknown opcode refused
        wb(1'b1, ADR_STATUS, 32'h0000_0006, v);
        run({OPC_XOR, 4'b1110, 4'h0, 9'd1, 9'd2});
        chk("skip_clocks", bcnt, 4);
        getr(9'd1, v);
        chk("skip_dst", v, d);
        wb(1'b0, ADR_STATUS, 32'h0000_0000, v);
        chk("skip_status", v, 32'h0000_0016);
        wb(1'b1, ADR_INSTR, {6'h3F, 8'h0F, 18'h0_0000}, v);
        wb(1'b0, ADR_STATUS, 32'h0000_0000, v);
        chk("ill_status", v, 32'h0000_000E);
        // Hub word store and load, slow and prompt hub
        for (int k = 0; k < 4; k++) begin
            ld = k[1];
            imm = k[0];
            dly <= 4'(k * 4);
            d = draw();
            s = draw();
            if (imm) s = {23'h0, s[8:0]};
            a = s[15:0];
            setr(9'd1, d);
            setr(9'd2, s);
            wb(1'b1, ADR_STATUS, 32'h0000_0004, v);
            run(ins(OPC_HUB_WORD, {2'b11, ld, imm}, 9'd1,
                    imm ? s[8:0] : 9'd2));
            chk("hub_clocks", bcnt >= 7 && bcnt <= 22, 1);
            chk("hub_len", bcnt, (dly > 4'h3) ? dly + 4 : 7);
            chk("hub_addr", s_addr, a);
            chk("hub_dir", s_we, !ld);
            getr(9'd1, v);
            chk("hub_c", c_o, 0);
            if (!ld) begin
                chk("hub_data", s_data, d[15:0]);
                chk("store_dst", v, d);
                chk("store_z", z_o, a[1]);
            end else begin
                chk("load_dst", v, {16'h0, ~a});
                chk("load_z", z_o, ~a == 16'h0000);
                wb(1'b0, ADR_HUB, 32'h0000_0000, v);
                chk("hub_reg", v, {~a, a});
            end
        end
        wrap_up();
    end
endmodule : wxz_exec_tb_top

// File: dv/wxz_hub_model.sv
// Stand-in for the shared memory hub: grants one slot per request.
// Assumes the core's clock; load data is the inverted slot address.
module wxz_hub_model (
    // System
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Core side
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic [3:0]  dly_i,
    output logic             grant_o,
    output logic [15:0]      rdata_o,
    // Last slot taken, for the bench
    output logic [15:0]      seen_addr_o,
    output logic [15:0]      seen_data_o,
    output logic             seen_we_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] wait_r;  // Cycles spent before the slot

    // Slot timing: grant after dly_i cycles, bounded by 4 bits
    always @(posedge clk_i) begin
        if (rst_i) begin
            grant_o <= 1'b0;
            wait_r  <= 4'h0;
            rdata_o <= 16'h5A5A;
        end else if (req_i && !grant_o && wait_r == dly_i) begin
            grant_o     <= 1'b1;
            rdata_o     <= ~addr_i;
            seen_addr_o <= addr_i;
            seen_data_o <= wdata_i;
            seen_we_o   <= we_i;
            wait_r      <= 4'h0;
        end else begin
            grant_o <= 1'b0;
            rdata_o <= ~rdata_o;  // Idle bus toggles, never a stale word
            if (req_i && !grant_o) wait_r <= wait_r + 4'h1;
        end
    end
endmodule : wxz_hub_model

// File: hw/wxz_alu.sv
// Combinational result and flag logic for the execution slice.
// Assumes operands already latched; the caller applies effects.
module wxz_alu import wxz_pkg::*; (
    // Operation and operands
    input  wire wxz_op_t     op_i,
    input  wire logic [31:0] dval_i,
    input  wire logic [31:0] sval_i,
    // Result and flag candidates
    output logic [31:0]      res_o,
    output logic             zero_o,
    output logic             carry_o,
    output logic             wr_o
);

    // Per-operation result and flags
    always_comb begin
        res_o   = WORD_RST;
        zero_o  = 1'b0;
        carry_o = 1'b0;
        wr_o    = 1'b0;
        unique case (op_i)
            OP_XOR: begin
                res_o   = dval_i ^ sval_i;
                zero_o  = (res_o == WORD_RST);
                carry_o = ^res_o;
                wr_o    = 1'b1;
            end
            OP_CMP: begin
                res_o   = dval_i - sval_i;
                zero_o  = (dval_i == sval_i);
                carry_o = (dval_i < sval_i);
                wr_o    = 1'b1;
            end
            OP_STORE: begin
                // Z set unless address sits on a long boundary
                zero_o  = sval_i[1];
                carry_o = 1'b0;
            end
            OP_LOAD, OP_NONE: begin
                wr_o = 1'b0;
            end
        endcase
    end

endmodule : wxz_alu

// File: hw/wxz_decode.sv
// Instruction decoder for the execution slice.
// Assumes a 32-bit instruction word laid out as in the package.
module wxz_decode import wxz_pkg::*; (
    // Instruction word
    input  wire logic [31:0] instr_i,
    // Decoded fields
    output wxz_op_t          op_o,
    output logic [8:0]       dst_o,
    output logic [8:0]       src_o,
    output logic             zeff_o,
    output logic             ceff_o,
    output logic             reff_o,
    output logic             imm_o,
    output logic [3:0]       cond_o
);

    logic [5:0] opc;  // Opcode field

    assign opc    = instr_i[OPC_LSB +: 6];
    assign dst_o  = instr_i[DST_LSB +: 9];
    assign src_o  = instr_i[SRC_LSB +: 9];
    assign zeff_o = instr_i[ZEFF_BIT];
    assign ceff_o = instr_i[CEFF_BIT];
    assign reff_o = instr_i[REFF_BIT];
    assign imm_o  = instr_i[IMM_BIT];
    assign cond_o = instr_i[COND_LSB +: 4];

    // Opcode to operation kind
    always_comb begin
        op_o = OP_NONE;
        if (opc == OPC_HUB_WORD) begin
            // Result bit turns the store into a load
            op_o = reff_o ? OP_LOAD : OP_STORE;
        end else if (opc == OPC_XOR) begin
            op_o = OP_XOR;
        end else if (opc == OPC_CMP) begin
            op_o = OP_CMP;
        end
    end

endmodule : wxz_decode

// File: hw/wxz_exec.sv
// Execution slice: hub word store/load, XOR and compare with flag effects.
// Assumes a classic Wishbone master and a hub arbiter on the same clock
// that pulses hub_grant_i for one cycle while hub_req_o is high.
module wxz_exec import wxz_pkg::*; (
    // System
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    // Hub memory port
    output logic             hub_req_o,
    output logic             hub_we_o,
    output logic [15:0]      hub_addr_o,
    output logic [15:0]      hub_wdata_o,
    input  wire logic        hub_grant_i,
    input  wire logic [15:0] hub_rdata_i,
    // Core status
    output logic             busy_o,
    output logic             z_o,
    output logic             c_o
);

    // Module state apart from the register file and blen_r
    typedef struct packed {
        wxz_st_t     st;     // Sequencer state
        logic        busy;   // Instruction in flight
        logic [4:0]  cnt;    // Cycles since start
        wxz_op_t     op;     // Operation in flight or last
        logic [8:0]  dst;    // Destination index
        logic        zeff;   // Zero flag write effect
        logic        ceff;   // Carry flag write effect
        logic        reff;   // Result write effect
        logic        imm;    // Source was a literal
        logic [31:0] instr;  // Last instruction word
        logic [31:0] dval;   // Destination operand
        logic [31:0] sval;   // Source operand
        logic        z;      // Zero flag
        logic        c;      // Carry flag
        logic        ill;    // Last word not decodable
        logic        skip;   // Last word failed condition
        logic [8:0]  ridx;   // Register window index
        logic        ack;    // Bus acknowledge
        logic [31:0] rdat;   // Bus read data
        logic        hreq;   // Hub request
        logic        hwe;    // Hub write direction
        logic [15:0] hrd;    // Word read from hub
    } wxz_state_t;

    wxz_state_t  s_r;        // Registered state
    wxz_state_t  s_nxt;      // Next state

    logic [31:0] rf_mem [512]; // Core register file

    logic        acc;        // Bus access taken this cycle
    logic [31:0] instr_w;    // Instruction with byte lanes merged
    wxz_op_t     dec_op;     // Decoded operation
    logic [8:0]  dec_dst;    // Decoded destination index
    logic [8:0]  dec_src;    // Decoded source field
    logic        dec_zeff;   // Decoded zero effect
    logic        dec_ceff;   // Decoded carry effect
    logic        dec_reff;   // Decoded result effect
    logic        dec_imm;    // Decoded immediate bit
    logic [3:0]  dec_cond;   // Decoded condition
    logic [31:0] src_val;    // Selected source operand
    logic [31:0] alu_res;    // ALU result
    logic        alu_zero;   // ALU zero candidate
    logic        alu_carry;  // ALU carry candidate
    logic        alu_wr;     // ALU has a result to write
    logic        retire_c;   // Instruction completes this cycle
    logic        rf_we_c;    // Register file write strobe
    logic [8:0]  rf_widx_c;  // Register file write index
    logic [31:0] rf_wdat_c;  // Register file write data
    logic [4:0]  cnt_inc;    // Saturating cycle count
    logic        zres;       // Zero flag value to apply
    logic        cres;       // Carry flag value to apply

    assign acc     = wb_cyc_i & wb_stb_i & ~s_r.ack;
    assign instr_w = wxz_merge(s_r.instr, wb_dat_i, wb_sel_i);
    assign cnt_inc = (s_r.cnt == CNT_TOP) ? s_r.cnt : s_r.cnt + 5'h01;

    // Literal source zero-extended, else register contents
    assign src_val = dec_imm ? {23'h00_0000, dec_src}
                             : rf_mem[dec_src];

    // Field decode of the word being written
    wxz_decode u_dec (
        .instr_i (instr_w),
        .op_o    (dec_op),
        .dst_o   (dec_dst),
        .src_o   (dec_src),
        .zeff_o  (dec_zeff),
        .ceff_o  (dec_ceff),
        .reff_o  (dec_reff),
        .imm_o   (dec_imm),
        .cond_o  (dec_cond)
    );

    // Result and flags of the latched operation
    wxz_alu u_alu (
        .op_i    (s_r.op),
        .dval_i  (s_r.dval),
        .sval_i  (s_r.sval),
        .res_o   (alu_res),
        .zero_o  (alu_zero),
        .carry_o (alu_carry),
        .wr_o    (alu_wr)
    );

    // Next-state logic: bus slave, sequencer and retirement
    always_comb begin
        s_nxt     = s_r;
        retire_c  = 1'b0;
        rf_we_c   = 1'b0;
        rf_widx_c = s_r.dst;
        rf_wdat_c = alu_res;
        zres      = alu_zero;
        cres      = alu_carry;
        s_nxt.ack = acc;
        // Register access
        if (acc) begin
            s_nxt.rdat = WORD_RST;
            case (wb_adr_i)
                ADR_INSTR: begin
                    s_nxt.rdat = s_r.instr;
                    // Words written while busy are dropped
                    if (wb_we_i && !s_r.busy) begin
                        s_nxt.instr = instr_w;
                        s_nxt.ill   = (dec_op == OP_NONE);
                        s_nxt.skip  = !wxz_cond_pass(dec_cond, s_r.z, s_r.c);
                        s_nxt.dst   = dec_dst;
                        s_nxt.dval  = rf_mem[dec_dst];
                        s_nxt.sval  = src_val;
                        s_nxt.imm   = dec_imm;
                        s_nxt.cnt   = 5'h00;
                        s_nxt.op    = dec_op;
                        s_nxt.zeff  = dec_zeff;
                        s_nxt.ceff  = dec_ceff;
                        s_nxt.reff  = dec_reff;
                        if (dec_op != OP_NONE) begin
                            s_nxt.st   = ST_EXEC;
                            s_nxt.busy = 1'b1;
                        end
                        // Failed condition runs as a no-op
                        if (!wxz_cond_pass(dec_cond, s_r.z, s_r.c)) begin
                            s_nxt.op   = OP_NONE;
                            s_nxt.zeff = 1'b0;
                            s_nxt.ceff = 1'b0;
                            s_nxt.reff = 1'b0;
                        end
                    end
                end
                ADR_STATUS: begin
                    s_nxt.rdat[ST_BUSY] = s_r.busy;
                    s_nxt.rdat[ST_Z]    = s_r.z;
                    s_nxt.rdat[ST_C]    = s_r.c;
                    s_nxt.rdat[ST_ILL]  = s_r.ill;
                    s_nxt.rdat[ST_SKIP] = s_r.skip;
                    // Software may seed the flags while idle
                    if (wb_we_i && wb_sel_i[0] && !s_r.busy) begin
                        s_nxt.z = wb_dat_i[ST_Z];
                        s_nxt.c = wb_dat_i[ST_C];
                    end
                end
                ADR_REG_IDX: begin
                    s_nxt.rdat[8:0] = s_r.ridx;
                    if (wb_we_i) begin
                        s_nxt.ridx = 9'(wxz_merge({23'h00_0000, s_r.ridx},
                                                  wb_dat_i, wb_sel_i));
                    end
                end
                ADR_REG_DATA: begin
                    s_nxt.rdat = rf_mem[s_r.ridx];
                    if (wb_we_i && !s_r.busy) begin
                        rf_we_c   = 1'b1;
                        rf_widx_c = s_r.ridx;
                        rf_wdat_c = wxz_merge(rf_mem[s_r.ridx],
                                              wb_dat_i, wb_sel_i);
                    end
                end
                ADR_HUB: begin
                    s_nxt.rdat = {s_r.hrd, s_r.sval[15:0]};
                end
                default: begin
                    s_nxt.rdat = WORD_RST;
                end
            endcase
        end
        // Sequencer
        unique case (s_r.st)
            ST_IDLE: begin
                s_nxt.hreq = 1'b0;
            end
            ST_EXEC: begin
                s_nxt.cnt = cnt_inc;
                if (s_r.op == OP_STORE || s_r.op == OP_LOAD) begin
                    // Wait for this core's hub slot
                    s_nxt.st   = ST_HUBW;
                    s_nxt.hreq = 1'b1;
                    s_nxt.hwe  = (s_r.op == OP_STORE);
                end else if (s_r.cnt == ALU_LAST) begin
                    retire_c = 1'b1;
                end
            end
            ST_HUBW: begin
                s_nxt.cnt = cnt_inc;
                if (hub_grant_i) begin
                    s_nxt.hreq = 1'b0;
                    s_nxt.st   = ST_FIN;
                    if (!s_r.hwe) s_nxt.hrd = hub_rdata_i;
                end
            end
            ST_FIN: begin
                s_nxt.cnt = cnt_inc;
                // Pad short hub waits up to the least length
                if (s_r.cnt >= HUB_LAST) retire_c = 1'b1;
            end
        endcase
        // Retirement: register and flag effects
        if (retire_c) begin
            s_nxt.st   = ST_IDLE;
            s_nxt.busy = 1'b0;
            if (s_r.op == OP_LOAD) begin
                rf_we_c   = 1'b1;
                rf_wdat_c = {16'h0000, s_r.hrd};
                zres      = (s_r.hrd == 16'h0000);
                cres      = 1'b0;
            end else begin
                // Store never writes back; XOR honours no-result
                rf_we_c = s_r.reff & alu_wr;
            end
            if (s_r.zeff) s_nxt.z = zres;
            if (s_r.ceff) s_nxt.c = cres;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r       <= '0;
            s_r.st    <= ST_IDLE;
            s_r.op    <= OP_NONE;
            s_r.z     <= FLAG_RST;
            s_r.c     <= FLAG_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Register file write port
    always_ff @(posedge clk_i) begin
        if (rf_we_c) rf_mem[rf_widx_c] <= rf_wdat_c;
    end

    assign wb_ack_o    = s_r.ack;
    assign wb_dat_o    = s_r.rdat;
    assign hub_req_o   = s_r.hreq;
    assign hub_we_o    = s_r.hwe;
    assign hub_addr_o  = s_r.sval[15:0];
    assign hub_wdata_o = s_r.dval[15:0];
    assign busy_o      = s_r.busy;
    assign z_o         = s_r.z;
    assign c_o         = s_r.c;

    // Busy length counter read only by the checks below
    logic [4:0] blen_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) blen_r <= 5'h00;
        else blen_r <= busy_o ? 5'(blen_r + 5'h01) : 5'h00;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence xor_start_s;
        s_r.st == ST_EXEC && s_r.cnt == 5'h00 && s_r.op == OP_XOR;
    endsequence
    sequence hub_done_s;
        $fell(busy_o) && (s_r.op == OP_STORE || s_r.op == OP_LOAD);
    endsequence

    store_data_a: assert property ($rose(hub_req_o) && hub_we_o
        |-> hub_wdata_o == rf_mem[s_r.dst][15:0])
        else $error("store word differs from destination low half");
    store_addr_a: assert property (hub_req_o && s_r.imm
        |-> hub_addr_o[15:9] == 7'h00)
        else $error("literal store address not zero-extended");
    hub_len_a: assert property (hub_done_s
        |-> blen_r >= 5'(HUB_MIN_CLOCKS) && blen_r <= 5'(HUB_MAX_CLOCKS))
        else $error("hub instruction shorter than least length");
    store_flag_a: assert property (retire_c && s_r.op == OP_STORE
        && s_r.zeff |=> z_o == $past(s_r.sval[1]))
        else $error("store Z does not follow long boundary");
    store_nowr_a: assert property (retire_c && s_r.op == OP_STORE
        |-> !rf_we_c)
        else $error("store wrote a register");
    z_keep_a: assert property (retire_c && !s_r.zeff
        |=> $stable(z_o))
        else $error("Z changed without zero effect");
    cmp_eq_a: assert property (retire_c && s_r.op == OP_CMP
        && s_r.zeff |=> z_o == $past(s_r.dval == s_r.sval))
        else $error("compare Z wrong");
    xor_time_a: assert property (xor_start_s |-> ##3 (retire_c
        && rf_we_c == s_r.reff) ##1 !busy_o && blen_r == 5'(ALU_CLOCKS))
        else $error("XOR not retired in four clocks");
    xor_zero_a: assert property (retire_c && s_r.op == OP_XOR
        && s_r.zeff |=> z_o == ($past(s_r.dval ^ s_r.sval) == 32'h0000_0000))
        else $error("XOR Z wrong");
    xor_par_a: assert property (retire_c && s_r.op == OP_XOR
        && s_r.ceff |=> c_o == ^$past(s_r.dval ^ s_r.sval))
        else $error("XOR C not parity");
    imm_src_a: assert property (s_r.st == ST_EXEC && s_r.imm
        |-> s_r.sval[31:9] == 23'h00_0000)
        else $error("literal source not zero-extended");

endmodule : wxz_exec
